// >>> include/ccs_defs.svh
// constants for the complement and compare-skip execution block
// assumes: included by its bare name from design and bench files
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH

// ----------------------------------------------------------------
// opcode fields
// ----------------------------------------------------------------
`define CCS_OPC_COMP 6'h07
`define CCS_OPC_CPEQ 7'h31
`define CCS_OPC_CPGT 7'h32
`define CCS_OPC_CPLT 7'h30
`define CCS_OPC_HI 15
`define CCS_COMP_LO 10
`define CCS_CMP_LO 9
`define CCS_BIT_D 9
`define CCS_BIT_A 8

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
`define CCS_IDX_MAX 8'h5f
`define CCS_ACC_SPLIT 8'h80
`define CCS_ACC_HI_BANK 4'hf
`define CCS_ACC_LO_BANK 4'h0

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CCS_RST_BYTE 8'h00
`define CCS_RST_ADDR 12'h000

`endif

// >>> include/ccs_pkg.sv
// types shared by the execution block and its bench
// assumes: compiled before any design file
`default_nettype none

package ccs_pkg;
   typedef enum logic [2:0] {
      CCS_OP_NONE = 3'b000,
      CCS_OP_COMP = 3'b001,
      CCS_OP_CPEQ = 3'b010,
      CCS_OP_CPGT = 3'b011,
      CCS_OP_CPLT = 3'b100
   } ccs_op_type;

   typedef enum logic [1:0] {
      CCS_ST_IDLE = 2'b00,
      CCS_ST_EXEC = 2'b01,
      CCS_ST_SKIP1 = 2'b10,
      CCS_ST_SKIP2 = 2'b11
   } ccs_state_type;

   // status flags written by the complement
   typedef struct packed {
      logic neg;
      logic zero;
   } ccs_flags_type;
endpackage : ccs_pkg
`default_nettype wire

// >>> hw/ccs_addr.sv
// operand address resolver: access bank, bank select, indexed offset
// assumes: 12-bit data space of 16 banks of 256 bytes
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module ccs_addr (
   input wire logic [7:0] i_f,          // operand address field
   input wire logic i_a,                // bank-select bit
   input wire logic [3:0] i_bsr,        // bank_select_register
   input wire logic i_ext_en,           // extended set enabled
   input wire logic [11:0] i_idx_base,  // index base pointer
   output logic [11:0] o_addr,          // resolved byte address
   output logic o_indexed               // indexed mode used
);
   // ----------------------------------------------------------------
   // resolution
   // ----------------------------------------------------------------
   // indexed override first, then bank register, then access bank
   always_comb begin
      o_indexed = ~i_a && i_ext_en && (i_f <= `CCS_IDX_MAX);
      if (o_indexed) begin
         o_addr = i_idx_base + {4'h0, i_f};
      end else if (i_a) begin
         o_addr = {i_bsr, i_f};
      end else if (i_f < `CCS_ACC_SPLIT) begin
         o_addr = {`CCS_ACC_LO_BANK, i_f};
      end else begin
         o_addr = {`CCS_ACC_HI_BANK, i_f};
      end
   end
endmodule : ccs_addr
`default_nettype wire

// >>> hw/ccs_exec.sv
// execution of complement and compare-skip byte instructions
// assumes: memory read data valid in the same clock that o_mem_addr first holds the address
// What this block does
// - complement result is inverse of byte
// - d bit picks memory or working register
// - a bit picks access bank or bank register
// - a=0, extended, f<=95 uses indexed offset
// - compares subtract unsigned, store no result
// - equal compare skips next instruction
// - greater compare skips on byte above register
// - less compare skips on byte below register
// - compare: one cycle, two when skipping, three when skipping a two-word instruction
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module ccs_exec (
   input wire logic i_clk_sys,          // core clock
   input wire logic i_rst_n,            // async reset, active low
   input wire logic i_op_valid,         // instruction offered
   input wire logic [15:0] i_op_word,   // instruction word
   input wire logic i_next_two_word,    // fetched next is 2 words
   input wire logic [7:0] i_working_register,       // working_register value
   input wire logic [3:0] i_bsr,        // bank_select_register
   input wire logic i_ext_en,           // extended set enabled
   input wire logic [11:0] i_idx_base,  // index base pointer
   input wire logic [7:0] i_mem_rdata,  // byte read at o_mem_addr
   output logic o_ready,                // can take an instruction
   output logic [11:0] o_mem_addr,      // operand address
   output logic [7:0] o_result,         // complement result
   output logic o_mem_we,               // write result to memory
   output logic o_working_register_we,              // write result to register
   output logic o_flag_we,              // flags update strobe
   output var ccs_pkg::ccs_flags_type o_flags, // new N and Z
   output logic o_skip,                 // discard fetched instr
   output logic o_nop                   // nop cycle in progress
);
   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   function automatic ccs_pkg::ccs_op_type op_decode(
      input logic [15:0] w
   );
      logic [6:0] hi7;
      hi7 = w[`CCS_OPC_HI:`CCS_CMP_LO];
      if (w[`CCS_OPC_HI:`CCS_COMP_LO] == `CCS_OPC_COMP) begin
         op_decode = ccs_pkg::CCS_OP_COMP;
      end else if (hi7 == `CCS_OPC_CPEQ) begin
         op_decode = ccs_pkg::CCS_OP_CPEQ;
      end else if (hi7 == `CCS_OPC_CPGT) begin
         op_decode = ccs_pkg::CCS_OP_CPGT;
      end else if (hi7 == `CCS_OPC_CPLT) begin
         op_decode = ccs_pkg::CCS_OP_CPLT;
      end else begin
         op_decode = ccs_pkg::CCS_OP_NONE;
      end
   endfunction : op_decode

   ccs_pkg::ccs_state_type state;
   ccs_pkg::ccs_state_type next_state;
   ccs_pkg::ccs_op_type op;
   ccs_pkg::ccs_op_type in_op;
   logic dest_mem;
   logic [11:0] next_addr;
   logic take;
   logic [8:0] diff;
   logic is_eq;
   logic is_gt;
   logic is_lt;
   logic is_cmp;
   logic skip_now;
   logic [7:0] inv;

   assign in_op = op_decode(i_op_word);
   assign o_ready = (state == ccs_pkg::CCS_ST_IDLE);
   assign take = o_ready && i_op_valid && (in_op != ccs_pkg::CCS_OP_NONE);

   // ----------------------------------------------------------------
   // operand address
   // ----------------------------------------------------------------
   ccs_addr u_addr (
      .i_f(i_op_word[7:0]),
      .i_a(i_op_word[`CCS_BIT_A]),
      .i_bsr(i_bsr),
      .i_ext_en(i_ext_en),
      .i_idx_base(i_idx_base),
      .o_addr(next_addr),
      .o_indexed()
   );

   // latch operation and address on accept
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         op <= ccs_pkg::CCS_OP_NONE;
         dest_mem <= 1'b0;
         o_mem_addr <= `CCS_RST_ADDR;
      end else if (take) begin
         op <= in_op;
         dest_mem <= i_op_word[`CCS_BIT_D];
         o_mem_addr <= next_addr;
      end
   end

   // ----------------------------------------------------------------
   // compare and complement datapath
   // ----------------------------------------------------------------
   // unsigned subtraction, borrow gives less-than
   assign diff = {1'b0, i_mem_rdata} - {1'b0, i_working_register};
   assign is_eq = (diff[7:0] == `CCS_RST_BYTE) && !diff[8];
   assign is_lt = diff[8];
   assign is_gt = !is_lt && !is_eq;
   assign inv = ~i_mem_rdata;
   assign is_cmp = (op == ccs_pkg::CCS_OP_CPEQ) ||
                   (op == ccs_pkg::CCS_OP_CPGT) ||
                   (op == ccs_pkg::CCS_OP_CPLT);

   // skip decision for the current compare
   always_comb begin
      case (op)
         ccs_pkg::CCS_OP_CPEQ: skip_now = is_eq;
         ccs_pkg::CCS_OP_CPGT: skip_now = is_gt;
         ccs_pkg::CCS_OP_CPLT: skip_now = is_lt;
         default: skip_now = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb begin
      case (state)
         ccs_pkg::CCS_ST_IDLE: begin
            next_state = take ? ccs_pkg::CCS_ST_EXEC : ccs_pkg::CCS_ST_IDLE;
         end
         ccs_pkg::CCS_ST_EXEC: begin
            next_state = (state == ccs_pkg::CCS_ST_EXEC && skip_now) ?
                         ccs_pkg::CCS_ST_SKIP1 :
                         ccs_pkg::CCS_ST_IDLE;
         end
         ccs_pkg::CCS_ST_SKIP1: begin
            next_state = i_next_two_word ? ccs_pkg::CCS_ST_SKIP2 :
                         ccs_pkg::CCS_ST_IDLE;
         end
         default: next_state = ccs_pkg::CCS_ST_IDLE;
      endcase
   end

   // state register
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state <= ccs_pkg::CCS_ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // discard strobe and nop cycles
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_skip <= 1'b0;
         o_nop <= 1'b0;
      end else begin
         o_skip <= (state == ccs_pkg::CCS_ST_EXEC) && skip_now;
         o_nop <= (next_state == ccs_pkg::CCS_ST_SKIP1) ||
                  (next_state == ccs_pkg::CCS_ST_SKIP2);
      end
   end

   // ----------------------------------------------------------------
   // result and flag writeback
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_result <= `CCS_RST_BYTE;
         o_mem_we <= 1'b0;
         o_working_register_we <= 1'b0;
      end else begin
         o_mem_we <= 1'b0;
         o_working_register_we <= 1'b0;
         if (state == ccs_pkg::CCS_ST_EXEC &&
             op == ccs_pkg::CCS_OP_COMP) begin
            o_result <= inv;
            o_mem_we <= dest_mem;
            o_working_register_we <= !dest_mem;
         end
      end
   end

   // flags only from the complement, compares leave them
   always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_flag_we <= 1'b0;
         o_flags <= '0;
      end else begin
         o_flag_we <= (state == ccs_pkg::CCS_ST_EXEC) &&
                      (op == ccs_pkg::CCS_OP_COMP);
         if (state == ccs_pkg::CCS_ST_EXEC &&
             op == ccs_pkg::CCS_OP_COMP) begin
            o_flags.neg <= inv[7];
            o_flags.zero <= (inv == `CCS_RST_BYTE);
         end
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);

   logic in_exec;
   assign in_exec = (state == ccs_pkg::CCS_ST_EXEC);

   a_comp_value: assert property (
      in_exec && op == ccs_pkg::CCS_OP_COMP |=>
      o_result == ~$past(i_mem_rdata))
      else $error("complement result wrong");
   a_dest_select: assert property (
      in_exec && op == ccs_pkg::CCS_OP_COMP |=>
      o_mem_we == $past(dest_mem) && o_working_register_we == !$past(dest_mem))
      else $error("complement destination wrong");
   a_bank_reg: assert property (
      take && i_op_word[`CCS_BIT_A] |=>
      o_mem_addr == {$past(i_bsr), $past(i_op_word[7:0])})
      else $error("bank register address wrong");
   a_indexed_addr: assert property (
      take && !i_op_word[`CCS_BIT_A] && i_ext_en &&
      i_op_word[7:0] <= `CCS_IDX_MAX |=>
      o_mem_addr == $past(i_idx_base) + {4'h0, $past(i_op_word[7:0])})
      else $error("indexed address wrong");
   a_cmp_nowrite: assert property (
      in_exec && is_cmp |=> !o_mem_we && !o_working_register_we)
      else $error("compare wrote a result");
   a_skip_equal: assert property (
      in_exec && op == ccs_pkg::CCS_OP_CPEQ |=>
      o_skip == ($past(i_mem_rdata) == $past(i_working_register)))
      else $error("equal skip wrong");
   a_skip_greater: assert property (
      in_exec && op == ccs_pkg::CCS_OP_CPGT |=>
      o_skip == ($past(i_mem_rdata) > $past(i_working_register)))
      else $error("greater skip wrong");
   a_skip_less: assert property (
      in_exec && op == ccs_pkg::CCS_OP_CPLT |=>
      o_skip == ($past(i_mem_rdata) < $past(i_working_register)))
      else $error("less skip wrong");
   a_one_nop: assert property (
      in_exec && skip_now ##1 !i_next_two_word |=> !o_nop && o_ready)
      else $error("single nop timing wrong");
   a_two_nops: assert property (
      in_exec && skip_now ##1 i_next_two_word |-> o_nop ##1 o_nop ##1
      (!o_nop && o_ready))
      else $error("double nop timing wrong");
   a_flags_kept: assert property (
      in_exec |=> o_flag_we == ($past(op) == ccs_pkg::CCS_OP_COMP))
      else $error("flag update wrong");

   c_comp_mem: cover property (
      in_exec && op == ccs_pkg::CCS_OP_COMP && dest_mem);
   c_skip_one: cover property (o_skip ##1 !o_nop);
   c_skip_two: cover property (o_nop [*2]);
   c_no_skip: cover property (in_exec && is_cmp && !skip_now);
endmodule : ccs_exec
`default_nettype wire

// >>> bench/tb_complement_compare_skip_ops.sv
// self-checking bench for the complement and compare-skip block
// assumes: ccs_pkg compiled first, ccs_defs.svh on the include path
`timescale 1ns/10ps
`default_nettype none
`include "ccs_defs.svh"

module tb_complement_compare_skip_ops;
   logic i_clk_sys, i_rst_n, i_op_valid, i_next_two_word, i_ext_en;
   logic [15:0] i_op_word;
   logic [7:0] i_working_register, i_mem_rdata;
   logic [3:0] i_bsr;
   logic [11:0] i_idx_base, o_mem_addr;
   logic o_ready, o_mem_we, o_working_register_we, o_flag_we, o_skip, o_nop;
   logic [7:0] o_result;
   ccs_pkg::ccs_flags_type o_flags;
   int err_total = 0;
   int checks_done = 0;

   ccs_exec dut_u (
      .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_op_valid(i_op_valid),
      .i_op_word(i_op_word), .i_next_two_word(i_next_two_word),
      .i_working_register(i_working_register), .i_bsr(i_bsr), .i_ext_en(i_ext_en),
      .i_idx_base(i_idx_base), .i_mem_rdata(i_mem_rdata),
      .o_ready(o_ready), .o_mem_addr(o_mem_addr), .o_result(o_result),
      .o_mem_we(o_mem_we), .o_working_register_we(o_working_register_we), .o_flag_we(o_flag_we),
      .o_flags(o_flags), .o_skip(o_skip), .o_nop(o_nop)
   );

   // 125 MHz core clock
   initial begin
      i_clk_sys = 1'b0;
      forever #4 i_clk_sys = ~i_clk_sys;
   end

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic results();
      $display("checks_done=%0d err_total=%0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // one instruction from offer to ready, judged cycle by cycle
   task automatic exec_op(input logic [15:0] w, input logic [7:0] wr,
         input logic [7:0] rd, input logic tw);
      logic [7:0] f;
      logic [7:0] r;
      logic [11:0] ea;
      logic comp;
      logic sk;
      int n;
      ccs_pkg::ccs_flags_type fl;
      f = w[7:0];
      r = ~rd;
      comp = (w[15:`CCS_COMP_LO] == `CCS_OPC_COMP);
      sk = (w[15:`CCS_CMP_LO] == `CCS_OPC_CPEQ && rd == wr)
         || (w[15:`CCS_CMP_LO] == `CCS_OPC_CPGT && rd > wr)
         || (w[15:`CCS_CMP_LO] == `CCS_OPC_CPLT && rd < wr);
      if (w[`CCS_BIT_A]) begin
         ea = {i_bsr, f};
      end else if (i_ext_en && f <= `CCS_IDX_MAX) begin
         ea = i_idx_base + {4'h0, f};
      end else begin
         ea = {(f < `CCS_ACC_SPLIT) ? `CCS_ACC_LO_BANK : `CCS_ACC_HI_BANK, f};
      end
      n = 0;
      while (o_ready !== 1'b1 && n < 20) begin
         @(posedge i_clk_sys);
         #1;
         n++;
      end
      fl = o_flags; // flags before this instruction
      i_op_valid = 1'b1;
      i_op_word = w;
      i_working_register = wr;
      i_next_two_word = tw;
      @(posedge i_clk_sys);
      #1;
      i_op_valid = 1'b0;
      i_mem_rdata = rd;
      chk({4'h0, o_mem_addr}, {4'h0, ea});
      chk(16'(o_ready), 16'h0000);
      @(posedge i_clk_sys);
      #1;
      i_mem_rdata = r; // operand released, show something else
      if (comp) begin
         chk({8'h00, o_result}, {8'h00, r});
         chk(16'({o_mem_we, o_working_register_we}), 16'({w[9], ~w[9]}));
         chk(16'({o_flag_we, o_flags}), 16'({1'b1, r[7], r == 8'h00}));
         chk(16'({o_skip, o_nop, o_ready}), 16'h0001);
      end else begin
         chk(16'({o_mem_we, o_working_register_we, o_flag_we}), 16'h0000);
         chk({14'h0000, o_flags}, {14'h0000, fl});
         chk(16'(o_skip), 16'(sk));
         chk(16'({o_nop, o_ready}), 16'({sk, ~sk}));
         if (sk) begin
            @(posedge i_clk_sys);
            #1;
            chk(16'({o_skip, o_nop, o_ready}), 16'({1'b0, tw, ~tw}));
            if (tw) begin
               @(posedge i_clk_sys);
               #1;
               chk(16'({o_nop, o_ready}), 16'h0001);
            end
         end
      end
   endtask : exec_op

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // complement to register and memory, zero and negative results
   task automatic comp_scn();
      logic [7:0] v [4] = '{8'h13, 8'hff, 8'h00, 8'h80};
      i_bsr = 4'h3;
      i_ext_en = 1'b0;
      for (int i = 0; i < 4; i++) begin
         exec_op({`CCS_OPC_COMP, i[0], i[1], 8'(8'h13 + i)}, 8'h55, v[i],
            1'b0);
      end
   endtask : comp_scn

   // bank choice, access split and indexed offset with wrap
   task automatic bank_scn();
      logic [9:0] t [8] = '{10'h07f, 10'h080, 10'h120, 10'h25f, 10'h260,
         10'h310, 10'h200, 10'h25f};
      i_bsr = 4'h5;
      for (int i = 0; i < 8; i++) begin
         i_ext_en = t[i][9];
         i_idx_base = (i > 5) ? 12'hfff : 12'h100;
         exec_op({`CCS_OPC_CPGT, t[i][8], t[i][7:0]}, 8'h40, 8'h40,
            1'b0);
      end
   endtask : bank_scn

   // every compare against below, equal, above and unsigned extremes
   task automatic cmp_scn();
      logic [15:0] p [5] = '{16'h7f80, 16'h8080, 16'h8180, 16'hff01,
         16'h00ff};
      logic [6:0] op [3] = '{`CCS_OPC_CPEQ, `CCS_OPC_CPGT, `CCS_OPC_CPLT};
      i_ext_en = 1'b0;
      for (int k = 0; k < 3; k++) begin
         for (int i = 0; i < 5; i++) begin
            exec_op({op[k], 1'b0, 8'h21}, p[i][7:0], p[i][15:8],
               i[0]);
         end
      end
   endtask : cmp_scn

   // undecodable words offered must be left alone
   task automatic refuse_scn();
      logic [15:0] w [2] = '{16'hffff, 16'h6600};
      for (int i = 0; i < 2; i++) begin
         i_op_valid = 1'b1;
         i_op_word = w[i];
         repeat (3) @(posedge i_clk_sys);
         #1;
         chk(16'({o_ready, o_mem_we, o_working_register_we, o_skip, o_nop}), 16'h0010);
      end
      i_op_valid = 1'b0;
   endtask : refuse_scn

   // ------------------------------------------------------------
   // main sequence and watchdog
   // ------------------------------------------------------------
   // reset, then the scenarios in turn
   initial begin
      i_rst_n = 1'b0;
      i_op_valid = 1'b0;
      i_op_word = 16'h0000;
      i_next_two_word = 1'b0;
      i_working_register = 8'h00;
      i_bsr = 4'h0;
      i_ext_en = 1'b0;
      i_idx_base = 12'h000;
      i_mem_rdata = 8'h00;
      repeat (3) @(posedge i_clk_sys);
      #1;
      chk(16'({o_ready, o_skip, o_nop, o_mem_we, o_flag_we}), 16'h0010);
      i_rst_n = 1'b1;
      @(posedge i_clk_sys);
      #1;
      comp_scn();
      bank_scn();
      cmp_scn();
      refuse_scn();
      results();
   end

   // cut a hang short well past the expected seventy-odd cycles
   initial begin
      repeat (3000) @(posedge i_clk_sys);
      err_total++;
      results();
   end
endmodule : tb_complement_compare_skip_ops
`default_nettype wire
